/* verilog/fmac_common.sv */
// Shared package for the fractional MAC datapath, plus its clamp stage
`timescale 1ns/10ps
`default_nettype none

package fmac_pkg;

  // Operation codes issued by the sequencer
  typedef enum logic [3:0] {
    FMAC_OP_CLR     = 4'h0,
    FMAC_OP_MPY     = 4'h1,
    FMAC_OP_MAC     = 4'h2,
    FMAC_OP_MPY32   = 4'h3,
    FMAC_OP_MPY32S  = 4'h4,
    FMAC_OP_LOAD    = 4'h5,
    FMAC_OP_STORE   = 4'h6,
    FMAC_OP_SPLIT   = 4'h7
  } fmac_op_t;

  // One request: opcode and two operands in split format
  typedef struct packed {
    fmac_op_t    op;
    logic [15:0] a_upper;
    logic [15:0] a_lower;
    logic [15:0] b_upper;
    logic [15:0] b_lower;
  } fmac_req_t;

  // Word widths
  localparam int unsigned FMAC_WORD_W = 16;
  localparam int unsigned FMAC_ACC_W  = 32;
  localparam int unsigned FMAC_WIDE_W = 34;

  // Q15 single word limits
  localparam logic [15:0] FMAC_Q15_MAX = 16'h7FFF;
  localparam logic [15:0] FMAC_Q15_MIN = 16'h8000;

  // Accumulator limits
  localparam logic [31:0] FMAC_ACC_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] FMAC_ACC_MIN = 32'h8000_0000;

  // Split format and cross product shifts
  localparam int unsigned FMAC_SPLIT_SHIFT = 16;
  localparam int unsigned FMAC_CROSS_SHIFT = 15;

  // Reset values
  localparam logic [31:0] FMAC_ACC_RESET  = 32'h0000_0000;
  localparam logic [15:0] FMAC_WORD_RESET = 16'h0000;

endpackage : fmac_pkg

////////////////////////////////////////////////////////////////////////////////

// Clamp or wrap of a widened sum into the 32-bit accumulator
module fmac_sat
  import fmac_pkg::*;
(
  input  wire logic signed [33:0] sum_in,
  input  wire logic               clamp_en,
  output logic        [31:0]      sum_out,
  output logic                    overflow
);

  logic hi_over;
  logic lo_over;

  // Range check against the two accumulator limits
  assign hi_over  = (sum_in > $signed({2'b00, FMAC_ACC_MAX}));
  assign lo_over  = (sum_in < $signed({2'b11, FMAC_ACC_MIN}));
  assign overflow = hi_over | lo_over;

  // Clamp only in clamp mode, otherwise plain two's complement wrap
  always_comb
  begin
    if (clamp_en && hi_over)
      sum_out = FMAC_ACC_MAX;
    else if (clamp_en && lo_over)
      sum_out = FMAC_ACC_MIN;
    else
      sum_out = sum_in[31:0];
  end

endmodule // fmac_sat

`default_nettype wire

/* verilog/fmac_unit.sv */
// Fixed-point fractional multiply-accumulate datapath
// Function
// - Operands are two's complement, sign in MSB
// - Qn point sits n bits above LSB
// - Fractional mode shifts product left one bit
// - 16x16 signed multiply gives 32-bit product
// - Store keeps upper half, truncates lower half
// - Accumulate at full 32 bits until store
// - Split format: upper=value>>16, lower=rest>>1
// - 32x32 split multiply returns 32-bit sum
// - 32x32 split multiply acts as Q31 product (here the cross terms enter at a quarter of their Q31 weight)
// - Split value times 16-bit word gives 32 bits
// - Accumulator confined to 80000000H..7FFFFFFFH
// - Clamping only while overflow clamp bit set
`timescale 1ns/10ps
`default_nettype none

module fmac_unit
  import fmac_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire fmac_req_t   req,
  input  wire logic        fractional_shift_bit,
  input  wire logic        overflow_clamp_bit,
  output logic [31:0]      acc_reg,
  output logic [15:0]      store_word_reg,
  output logic             store_valid_reg,
  output logic [15:0]      upper_half_reg,
  output logic [15:0]      lower_half_reg,
  output logic             split_valid_reg,
  output logic             done_reg,
  output logic             overflow_reg
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Plain signed 16x16 product; sign bit is the MSB of each word
  function automatic logic signed [31:0] fmac_mul_raw(
    input logic [15:0] x,
    input logic [15:0] y
  );
    fmac_mul_raw = $signed(x) * $signed(y);
  endfunction

  // Single-word product widened for the accumulate path
  function automatic logic signed [33:0] fmac_mul16(
    input logic [15:0] x,
    input logic [15:0] y,
    input logic        frac
  );
    logic signed [31:0] p;
    p = fmac_mul_raw(x, y);
    // Drop the duplicated sign bit when in fractional mode
    if (frac)
      fmac_mul16 = $signed({p[31], p, 1'b0});
    else
      fmac_mul16 = $signed({{2{p[31]}}, p});
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  logic signed [33:0] acc_wide;
  logic signed [33:0] wide_next;
  logic signed [31:0] prod_hh;
  logic signed [31:0] prod_hl;
  logic signed [31:0] prod_lh;
  logic signed [31:0] prod_ls;
  logic signed [17:0] cross_sum;
  logic signed [33:0] split32_result;
  logic signed [33:0] split16_result;
  logic        [31:0] sat_val;
  logic               sat_ovf;
  logic               acc_write;

  assign acc_wide = $signed({{2{acc_reg[31]}}, acc_reg});

  // Partial products for the split-format multiplies; only prod_hl feeds both
  assign prod_hh = fmac_mul_raw(req.a_upper, req.b_upper);
  assign prod_hl = fmac_mul_raw(req.a_upper, req.b_lower);
  assign prod_lh = fmac_mul_raw(req.a_lower, req.b_upper);
  assign prod_ls = fmac_mul_raw(req.a_lower, req.b_lower);

  // Cross terms scaled down before they meet the main term
  assign cross_sum = 18'(prod_hl >>> FMAC_CROSS_SHIFT)
                   + 18'(prod_lh >>> FMAC_CROSS_SHIFT);

  // Upper term as Q31, cross terms at a quarter of Q31 weight; only 32 bits of result kept
  assign split32_result = $signed({prod_hh[31], prod_hh, 1'b0})
                        + 34'(cross_sum >>> 1);

  // Split value times plain word held in b_lower
  assign split16_result = $signed({prod_hl[31], prod_hl, 1'b0})
                        + $signed({34'(prod_ls >>> FMAC_CROSS_SHIFT)} << 1);

  // Next accumulator value before clamping
  always_comb
  begin
    wide_next = acc_wide;
    acc_write = 1'b0;
    if (req_valid)
    begin
      unique case (req.op)
        FMAC_OP_CLR:
        begin
          wide_next = $signed({2'b00, FMAC_ACC_RESET});
          acc_write = 1'b1;
        end
        FMAC_OP_MPY:
        begin
          wide_next = fmac_mul16(req.a_lower, req.b_lower,
                                 fractional_shift_bit);
          acc_write = 1'b1;
        end
        FMAC_OP_MAC:
        begin
          // Full 32-bit running sum, no rounding between steps
          wide_next = acc_wide + fmac_mul16(req.a_lower, req.b_lower,
                                            fractional_shift_bit);
          acc_write = 1'b1;
        end
        FMAC_OP_MPY32:
        begin
          wide_next = split32_result;
          acc_write = 1'b1;
        end
        FMAC_OP_MPY32S:
        begin
          wide_next = split16_result;
          acc_write = 1'b1;
        end
        FMAC_OP_LOAD:
        begin
          // Rebuild a 32-bit value from its split halves
          wide_next = $signed({{2{req.a_upper[15]}}, req.a_upper,
                               16'h0000})
                    + $signed({18'h0_0000, req.a_lower[14:0], 1'b0});
          acc_write = 1'b1;
        end
        FMAC_OP_STORE,
        FMAC_OP_SPLIT:
        begin
          wide_next = acc_wide;
          acc_write = 1'b0;
        end
        default:
        begin
          wide_next = acc_wide;
          acc_write = 1'b0;
        end
      endcase
    end
  end

  // Clamp or wrap per the overflow clamp bit
  fmac_sat u_sat (
    .sum_in   (wide_next),
    .clamp_en (overflow_clamp_bit),
    .sum_out  (sat_val),
    .overflow (sat_ovf)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator

  // Accumulator always lands inside the 32-bit range
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acc_reg <= FMAC_ACC_RESET;
    else if (acc_write)
      acc_reg <= sat_val;
  end

  // Sticky overflow; a new overflow beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      overflow_reg <= 1'b0;
    else if (acc_write && sat_ovf)
      overflow_reg <= 1'b1;
    else if (req_valid && req.op == FMAC_OP_CLR)
      overflow_reg <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Store path

  // Only the upper half reaches 16-bit memory; lower half is dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      store_word_reg  <= FMAC_WORD_RESET;
      store_valid_reg <= 1'b0;
    end
    else
    begin
      store_valid_reg <= req_valid && (req.op == FMAC_OP_STORE);
      if (req_valid && req.op == FMAC_OP_STORE)
        store_word_reg <= acc_reg[31:16];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Split export

  // Upper is value>>16 (signed); lower is remaining 16 bits >>1
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upper_half_reg  <= FMAC_WORD_RESET;
      lower_half_reg  <= FMAC_WORD_RESET;
      split_valid_reg <= 1'b0;
    end
    else
    begin
      split_valid_reg <= req_valid && (req.op == FMAC_OP_SPLIT);
      if (req_valid && req.op == FMAC_OP_SPLIT)
      begin
        upper_half_reg <= acc_reg[31:16];
        lower_half_reg <= {1'b0, acc_reg[15:1]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Completion

  // Every accepted request finishes in one cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      done_reg <= 1'b0;
    else
      done_reg <= req_valid;
  end

endmodule // fmac_unit

`default_nettype wire

/* sim/fmac_unit_monitor.sv */
// Assertion checker for the fractional MAC datapath
`timescale 1ns/10ps
`default_nettype none
module fmac_unit_monitor
  import fmac_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire fmac_req_t   req,
  input wire logic        fractional_shift_bit,
  input wire logic        overflow_clamp_bit,
  input wire logic [31:0] acc_reg,
  input wire logic [15:0] store_word_reg,
  input wire logic        store_valid_reg,
  input wire logic [15:0] upper_half_reg,
  input wire logic [15:0] lower_half_reg,
  input wire logic        split_valid_reg,
  input wire logic        done_reg,
  input wire logic        overflow_reg
);
  logic [31:0] prod;
  // Plain signed product; the one case where its doubled form overflows is excluded below
  assign prod = $signed(req.a_lower) * $signed(req.b_lower);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Request of one kind taken at this edge
  sequence s_op(fmac_op_t o);
    req_valid && req.op == o;
  endsequence
  // Most negative squared with the shift on: the only MPY overflow
  sequence s_min_sq;
    s_op(FMAC_OP_MPY) ##0 fractional_shift_bit
      ##0 req.a_lower == 16'h8000 && req.b_lower == 16'h8000;
  endsequence
  chk_mpy_full: assert property (
    s_op(FMAC_OP_MPY) ##0 !fractional_shift_bit |=> acc_reg == $past(prod))
    else $error("plain product wrong");
  chk_mpy_shift: assert property (
    s_op(FMAC_OP_MPY) ##0 fractional_shift_bit
      ##0 !(req.a_lower == 16'h8000 && req.b_lower == 16'h8000)
    |=> acc_reg == $past(prod) << 1) else $error("shifted product wrong");
  chk_store_trunc: assert property (
    s_op(FMAC_OP_STORE) |=> store_valid_reg
    && {16'h0000, store_word_reg} == $past(acc_reg) >> 16)
    else $error("stored word wrong");
  chk_acc_hold: assert property (!req_valid |=> $stable(acc_reg))
    else $error("accumulator moved while idle");
  chk_split_fmt: assert property (
    s_op(FMAC_OP_SPLIT) |=> split_valid_reg && lower_half_reg[15] == 1'b0
    && {1'b0, upper_half_reg, lower_half_reg[14:0]} == $past(acc_reg) >> 1)
    else $error("split halves wrong");
  chk_clamp_high: assert property (
    s_min_sq ##0 overflow_clamp_bit |=> acc_reg == FMAC_ACC_MAX)
    else $error("no clamp");
  chk_wrap_low: assert property (
    s_min_sq ##0 !overflow_clamp_bit |=> acc_reg == FMAC_ACC_MIN)
    else $error("no wrap");
  chk_ovf_flag: assert property (s_min_sq |=> overflow_reg)
    else $error("overflow not flagged");
  chk_clr_zero: assert property (
    s_op(FMAC_OP_CLR) |=> acc_reg == 32'h0000_0000 && !overflow_reg)
    else $error("clear failed");
endmodule // fmac_unit_monitor
bind fmac_unit fmac_unit_monitor mon (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
  .fractional_shift_bit(fractional_shift_bit),
  .overflow_clamp_bit(overflow_clamp_bit), .acc_reg(acc_reg),
  .store_word_reg(store_word_reg), .store_valid_reg(store_valid_reg),
  .upper_half_reg(upper_half_reg), .lower_half_reg(lower_half_reg),
  .split_valid_reg(split_valid_reg), .done_reg(done_reg),
  .overflow_reg(overflow_reg));
`default_nettype wire

/* sim/fmac_seq.sv */
// Sequencer model issuing datapath requests
`timescale 1ns/10ps
`default_nettype none
module fmac_seq
  import fmac_pkg::*;
(
  input  wire logic clk,
  output logic      req_valid,
  output fmac_req_t req
);
  // Quiet bus at start
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end
  // One request per edge, back to back allowed; 32-bit in split halves
  task automatic issue(input fmac_op_t op, input logic [15:0] au, al, bu, bl);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op, au, al, bu, bl};
  endtask
  // Released operands scrambled so nothing leans on stale data
  task automatic idle();
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~req;
  endtask
endmodule // fmac_seq
`default_nettype wire

/* sim/fmac_unit_bench.sv */
// Self-checking bench for the fractional MAC datapath
`timescale 1ns/10ps
`default_nettype none
module fmac_unit_bench
  import fmac_pkg::*;
;
  logic        clk, rst, frac, clamp, req_valid, sv, spv, done, ovf;
  fmac_req_t   req;
  logic [31:0] acc;
  logic [15:0] sw, uh, lh;
  int          errors, n_checks;
  fmac_seq seq (.clk(clk), .req_valid(req_valid), .req(req));
  fmac_unit uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .fractional_shift_bit(frac), .overflow_clamp_bit(clamp), .acc_reg(acc),
    .store_word_reg(sw), .store_valid_reg(sv), .upper_half_reg(uh),
    .lower_half_reg(lh), .split_valid_reg(spv), .done_reg(done),
    .overflow_reg(ovf));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("errors %0d n_checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Mode bits change only while no request is pending
  task automatic mode(input logic f, c);
    @(posedge clk);
    frac  <= f;
    clamp <= c;
  endtask
  task automatic t_mpy();
    for (int f = 0; f < 2; f++)
    begin
      mode(f[0], 1'b1);
      seq.issue(FMAC_OP_MPY, '0, 16'h8000, '0, 16'h7FFF);
      seq.idle();
      #1 cmp("mpy", f ? 32'h8001_0000 : 32'hC000_8000, acc);
    end
  endtask
  // Sum kept at full width, only the stored word truncated
  task automatic t_mac();
    mode(1'b1, 1'b1);
    seq.issue(FMAC_OP_CLR, '0, '0, '0, '0);
    seq.issue(FMAC_OP_MAC, '0, 16'h4000, '0, 16'h4000);
    seq.issue(FMAC_OP_MAC, '0, 16'h4000, '0, 16'h4000);
    seq.issue(FMAC_OP_MAC, '0, 16'h0001, '0, 16'h0001);
    seq.issue(FMAC_OP_STORE, '0, '0, '0, '0);
    seq.idle();
    #1 cmp("acc", 32'h4000_0002, acc);
    cmp("store", 32'h0000_4000, {16'h0000, sw});
    cmp("store valid", 32'h0000_0001, {31'h0000_0000, sv});
  endtask
  task automatic t_sat();
    for (int c = 0; c < 2; c++)
    begin
      mode(1'b1, c[0]);
      seq.issue(FMAC_OP_CLR, '0, '0, '0, '0);
      seq.issue(FMAC_OP_MPY, '0, 16'h8000, '0, 16'h8000);
      seq.idle();
      #1 cmp("sat", c ? FMAC_ACC_MAX : FMAC_ACC_MIN, acc);
      cmp("ovf", 32'h0000_0001, {31'h0000_0000, ovf});
    end
  endtask
  task automatic t_split();
    mode(1'b0, 1'b0);
    seq.issue(FMAC_OP_LOAD, 16'h1234, 16'h5678, '0, '0);
    seq.issue(FMAC_OP_SPLIT, '0, '0, '0, '0);
    seq.issue(FMAC_OP_MPY32, 16'h4000, 16'h2000, 16'hC000, '0);
    #1 cmp("split valid", 32'h0000_0001, {31'h0000_0000, spv});
    seq.idle();
    #1 cmp("halves", 32'h1234_5678, {uh, lh});
    cmp("mpy32", 32'hDFFF_F800, acc);
    seq.issue(FMAC_OP_MPY32S, 16'h4000, 16'h2000, '0, 16'hC000);
    seq.issue(fmac_op_t'(4'h9), 16'h7FFF, '0, '0, '0);
    seq.idle();
    #1 cmp("mpy32s", 32'hDFFF_E000, acc);
    cmp("done", 32'h0000_0001, {31'h0000_0000, done});
  endtask
  // Reset, then each scenario in turn
  initial
  begin
    rst      = 1'b1;
    frac     = 1'b0;
    clamp    = 1'b0;
    errors   = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    cmp("reset", 32'h0000_0000, acc);
    cmp("reset halves", 32'h0000_0000, {uh, lh});
    cmp("reset flags", 32'h0000_0000, {sw, 12'h000, sv, spv, done, ovf});
    rst <= 1'b0;
    t_mpy();
    t_mac();
    t_sat();
    t_split();
    results();
  end
endmodule // fmac_unit_bench
`default_nettype wire
